// ==== hw/ms_timebase.sv ====
// millisecond tick and the two led blink phases
// assumes core_clk is the only clock; outputs are enables, not clocks
`timescale 1ns/1ps
module ms_timebase #(
	parameter int unsigned CYC_PER_MS = power_seq_pkg::CYC_PER_MS
) (
	input  wire logic core_clk,
	input  wire logic reset_n,
	output logic      ms_tick,
	output logic      blink_slow,
	output logic      blink_fast
);

	localparam int unsigned DIV_W = $clog2(CYC_PER_MS);

	logic [DIV_W-1:0]            div_q;
	power_seq_pkg::ms_cnt_t      slow_q;
	power_seq_pkg::ms_cnt_t      fast_q;

	generate
		if (CYC_PER_MS < 2) begin : g_bad_div
			$error("ms_timebase needs at least two cycles per ms");
		end
	endgenerate

	// divider: one-cycle pulse every CYC_PER_MS cycles
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q   <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (div_q == DIV_W'(CYC_PER_MS - 1));
			div_q   <= (div_q == DIV_W'(CYC_PER_MS - 1)) ? '0 : div_q + 1'b1;
		end
	end

	// blink phases toggle every half period, counted in ms ticks
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slow_q     <= '0;
			fast_q     <= '0;
			blink_slow <= 1'b0;
			blink_fast <= 1'b0;
		end else if (ms_tick) begin
			slow_q <= (slow_q == power_seq_pkg::SLOW_HALF_TICKS - 1'b1) ? '0 : slow_q + 1'b1;
			fast_q <= (fast_q == power_seq_pkg::FAST_HALF_TICKS - 1'b1) ? '0 : fast_q + 1'b1;
			if (slow_q == power_seq_pkg::SLOW_HALF_TICKS - 1'b1) begin
				blink_slow <= ~blink_slow;
			end
			if (fast_q == power_seq_pkg::FAST_HALF_TICKS - 1'b1) begin
				blink_fast <= ~blink_fast;
			end
		end
	end

endmodule

// ==== hw/pin_sync.sv ====
// two-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; no bus coherence is promised
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned           WIDTH = 1,
	parameter logic [WIDTH-1:0]      RST   = '0
) (
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	input  wire logic [WIDTH-1:0]    async_in,
	output logic      [WIDTH-1:0]    sync_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= RST;
			sync_out <= RST;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ==== hw/power_status_sequencer.sv ====
// rail sequencing, power-good timing, fan boost and front led of a dc-dc front end
// assumes all pins_in bits are asynchronous levels; rail enables drive the converters
//
// What this block does
// - power good high only while standby and main rails both regulate.
// - fan boost request low forces fan maximum, ignored in standby mode.
// - system fault shutdown high shuts the power outputs down.
// - power good rises 5 to 400 ms after both rails regulate.
// - power good falls at least 1 ms before main rail is dropped.
// - on dc input loss, power good falls no sooner than 4 ms later.
// - power good stays low at least 100 ms once it has fallen.
// - main rail regulates 5 to 400 ms after output enable goes low.
// - main rail disabled within 1 ms of output enable going high.
// - power good falls within 4 ms of output enable going high.
// - a rail that drops out stays off about 1 s before restart.
// - main rail starts 50 to 1000 ms after standby rail.
// - led pattern picked by fixed priority, first match wins.
// - led off with no output or input undervoltage and no paralleled standby.
// - led blinks green 1 Hz while output enable is high.
// - solid amber for over-temperature or over-voltage shutdown.
// - amber blinks 1 Hz for temperature warning or minor fan error.
// - green blinks 2 Hz during firmware bootload.
// - solid green when both rails regulate and nothing higher applies.
// - output enable returning high clears latched faults.
// - alert output goes low together with any amber led pattern.
`timescale 1ns/1ps
module power_status_sequencer #(
	parameter int unsigned CYC_PER_MS = power_seq_pkg::CYC_PER_MS
) (
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	input  wire power_seq_pkg::pins_s pins_in,
	output logic                      standby_rail_en,
	output logic                      main_rail_en,
	output logic                      power_good_out,
	output logic                      fan_max_out,
	output logic                      led_green,
	output logic                      led_amber,
	output logic                      alert_out_n
);

	localparam int unsigned WARN_CYC = power_seq_pkg::T_PG_WARN_MS * CYC_PER_MS;
	localparam int unsigned WARN_W   = $clog2(WARN_CYC + 2);

	generate
		if (CYC_PER_MS < 2) begin : g_bad_rate
			$error("power_status_sequencer needs at least two cycles per ms");
		end
	endgenerate

	power_seq_pkg::pins_s   s;
	logic                   ms_tick;
	logic                   blink_slow;
	logic                   blink_fast;
	logic                   oe_n_prev_q;
	logic                   oe_rise;
	logic                   sys_fault_q;
	logic                   prot_fault_q;
	logic                   prot_event;
	power_seq_pkg::ms_cnt_t dc_lost_q;
	logic                   dc_dropped;
	logic                   stby_up_q;
	power_seq_pkg::ms_cnt_t stby_off_q;
	power_seq_pkg::main_e   main_q;
	power_seq_pkg::ms_cnt_t main_cnt_q;
	logic [WARN_W-1:0]      warn_cnt_q;
	logic                   main_up_q;
	logic                   stop_req;
	power_seq_pkg::ms_cnt_t pg_del_q;
	power_seq_pkg::ms_cnt_t pg_low_q;
	logic                   pg_ok;
	power_seq_pkg::led_e    led_d;
	power_seq_pkg::led_e    led_mode_q;

	pin_sync #(
		.WIDTH ($bits(power_seq_pkg::pins_s)),
		.RST   (power_seq_pkg::PINS_RST)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in (pins_in),
		.sync_out (s)
	);

	ms_timebase #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timebase (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.ms_tick    (ms_tick),
		.blink_slow (blink_slow),
		.blink_fast (blink_fast)
	);

	// saturating ms counter step, shared by the counters that count up in ms ticks
	function automatic power_seq_pkg::ms_cnt_t sat_inc(input power_seq_pkg::ms_cnt_t v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	assign oe_rise    = s.output_enable_n & ~oe_n_prev_q;
	assign prot_event = s.over_temp_shutdown | s.over_voltage_shutdown | s.over_current_shutdown;
	assign dc_dropped = (dc_lost_q >= power_seq_pkg::HOLDUP_TICKS);

	// output enable edge detect for fault clearing
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_n_prev_q <= 1'b1;
		end else begin
			oe_n_prev_q <= s.output_enable_n;
		end
	end

	// latched faults: a new event in the clearing cycle wins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_fault_q  <= 1'b0;
			prot_fault_q <= 1'b0;
		end else begin
			sys_fault_q  <= s.system_fault_shutdown | (sys_fault_q & ~oe_rise);
			prot_fault_q <= prot_event | (prot_fault_q & ~oe_rise);
		end
	end

	// input loss takes power good and the rails down only after the holdup time, so short dips ride through
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dc_lost_q <= '0;
		end else if (s.dc_input_ok) begin
			dc_lost_q <= '0;
		end else if (ms_tick) begin
			dc_lost_q <= sat_inc(dc_lost_q);
		end
	end

	// standby rail: on with input, back-off after it drops out on its own
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			standby_rail_en <= 1'b0;
			stby_up_q       <= 1'b0;
			stby_off_q      <= '0;
		end else if (standby_rail_en) begin
			stby_up_q <= stby_up_q | s.standby_rail_ok;
			if (dc_dropped || sys_fault_q) begin
				standby_rail_en <= 1'b0;
				stby_up_q       <= 1'b0;
			end else if (stby_up_q && !s.standby_rail_ok) begin
				standby_rail_en <= 1'b0;
				stby_up_q       <= 1'b0;
				stby_off_q      <= power_seq_pkg::RAIL_OFF_TICKS;
			end
		end else if (stby_off_q != '0) begin
			if (ms_tick) begin
				stby_off_q <= stby_off_q - 1'b1;
			end
		end else if (s.dc_input_ok && !sys_fault_q) begin
			standby_rail_en <= 1'b1;
		end
	end

	// any reason to take the main rail down in an orderly way
	assign stop_req = s.output_enable_n | prot_fault_q | sys_fault_q | dc_dropped
		| ~standby_rail_en | ~s.standby_rail_ok;

	// main rail sequencer; power good is dropped on entry to warn, the rail a ms later
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			main_q       <= power_seq_pkg::MAIN_IDLE;
			main_cnt_q   <= '0;
			warn_cnt_q   <= '0;
			main_rail_en <= 1'b0;
			main_up_q    <= 1'b0;
		end else begin
			case (main_q)
				power_seq_pkg::MAIN_IDLE: begin
					if (!stop_req && s.dc_input_ok) begin
						main_q     <= power_seq_pkg::MAIN_DELAY;
						main_cnt_q <= power_seq_pkg::SEQ_DELAY_TICKS;
					end
				end
				power_seq_pkg::MAIN_DELAY: begin
					if (stop_req || !s.dc_input_ok) begin
						main_q <= power_seq_pkg::MAIN_IDLE;
					end else if (ms_tick) begin
						main_cnt_q <= main_cnt_q - 1'b1;
						if (main_cnt_q == power_seq_pkg::ms_cnt_t'(1)) begin
							main_q       <= power_seq_pkg::MAIN_ON;
							main_rail_en <= 1'b1;
						end
					end
				end
				power_seq_pkg::MAIN_ON: begin
					main_up_q <= main_up_q | s.main_rail_ok;
					if (main_up_q && !s.main_rail_ok) begin
						main_q       <= power_seq_pkg::MAIN_BACKOFF;
						main_rail_en <= 1'b0;
						main_up_q    <= 1'b0;
						main_cnt_q   <= power_seq_pkg::RAIL_OFF_TICKS;
					end else if (stop_req) begin
						main_q     <= power_seq_pkg::MAIN_WARN;
						warn_cnt_q <= WARN_W'(WARN_CYC - 1);
					end
				end
				power_seq_pkg::MAIN_WARN: begin
					if (warn_cnt_q == '0) begin
						main_q       <= power_seq_pkg::MAIN_IDLE;
						main_rail_en <= 1'b0;
						main_up_q    <= 1'b0;
					end else begin
						warn_cnt_q <= warn_cnt_q - 1'b1;
					end
				end
				power_seq_pkg::MAIN_BACKOFF: begin
					if (main_cnt_q == '0) begin
						main_q <= power_seq_pkg::MAIN_IDLE;
					end else if (ms_tick) begin
						main_cnt_q <= main_cnt_q - 1'b1;
					end
				end
				default: begin
					main_q       <= power_seq_pkg::MAIN_IDLE;
					main_rail_en <= 1'b0;
				end
			endcase
		end
	end

	// power good may only stand while the sequencer is settled on and both rails regulate
	assign pg_ok = s.standby_rail_ok & s.main_rail_ok & (main_q == power_seq_pkg::MAIN_ON)
		& ~stop_req;

	// settle time after both rails regulate, and time held low after a drop
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pg_del_q <= '0;
			pg_low_q <= '0;
		end else begin
			if (!pg_ok) begin
				pg_del_q <= '0;
			end else if (ms_tick) begin
				pg_del_q <= sat_inc(pg_del_q);
			end
			if (power_good_out) begin
				pg_low_q <= '0;
			end else if (ms_tick) begin
				pg_low_q <= sat_inc(pg_low_q);
			end
		end
	end

	// power good output; falls the cycle after any cause disappears
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			power_good_out <= 1'b0;
		end else begin
			power_good_out <= pg_ok && (pg_del_q >= power_seq_pkg::PG_DELAY_TICKS)
				&& (power_good_out || pg_low_q >= power_seq_pkg::PG_LOW_TICKS);
		end
	end

	// fan boost only counts while the main output is requested
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fan_max_out <= 1'b0;
		end else begin
			fan_max_out <= ~s.fan_boost_request_n & ~s.output_enable_n;
		end
	end

	// led precedence; rail faults count only for a rail that is meant to be on
	always_comb begin
		logic no_power;
		no_power = ~(s.standby_rail_ok | s.main_rail_ok) | ~s.dc_input_ok;
		if (no_power && !s.paralleled_standby_ok) begin
			led_d = power_seq_pkg::LED_OFF;
		end else if (s.output_enable_n || no_power
			|| (standby_rail_en && !s.standby_rail_ok)
			|| (main_rail_en && !s.main_rail_ok)) begin
			led_d = power_seq_pkg::LED_GREEN_SLOW;
		end else if (prot_fault_q || prot_event || s.fan_error_major) begin
			led_d = power_seq_pkg::LED_AMBER;
		end else if (s.over_temp_warning || s.fan_error_minor) begin
			led_d = power_seq_pkg::LED_AMBER_SLOW;
		end else if (s.bootload_active) begin
			led_d = power_seq_pkg::LED_GREEN_FAST;
		end else if (s.standby_rail_ok && s.main_rail_ok) begin
			led_d = power_seq_pkg::LED_GREEN;
		end else begin
			led_d = power_seq_pkg::LED_OFF;
		end
	end

	// led drive and alert share one register stage so they change together
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			led_mode_q  <= power_seq_pkg::LED_OFF;
			led_green   <= 1'b0;
			led_amber   <= 1'b0;
			alert_out_n <= 1'b1;
		end else begin
			led_mode_q  <= led_d;
			led_green   <= (led_d == power_seq_pkg::LED_GREEN)
				|| (led_d == power_seq_pkg::LED_GREEN_SLOW && blink_slow)
				|| (led_d == power_seq_pkg::LED_GREEN_FAST && blink_fast);
			led_amber   <= (led_d == power_seq_pkg::LED_AMBER)
				|| (led_d == power_seq_pkg::LED_AMBER_SLOW && blink_slow);
			alert_out_n <= ~(led_d == power_seq_pkg::LED_AMBER
				|| led_d == power_seq_pkg::LED_AMBER_SLOW);
		end
	end

	// helper counters: cycles power good has been low, cycles main stays enabled after enable went away
	logic [WARN_W-1:0] pg_low_cyc_q;
	logic [WARN_W-1:0] oe_off_cyc_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pg_low_cyc_q <= '0;
			oe_off_cyc_q <= '0;
		end else begin
			pg_low_cyc_q <= power_good_out ? '0 : ((&pg_low_cyc_q) ? pg_low_cyc_q
				: pg_low_cyc_q + 1'b1);
			oe_off_cyc_q <= (!s.output_enable_n || !main_rail_en) ? '0
				: ((&oe_off_cyc_q) ? oe_off_cyc_q : oe_off_cyc_q + 1'b1);
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	chk_pg_both_rails: assert property (power_good_out |-> $past(s.standby_rail_ok)
		&& $past(s.main_rail_ok)) else $error("power good without both rails");
	chk_fan_standby: assert property (s.output_enable_n |=> !fan_max_out)
		else $error("fan boost honoured in standby");
	chk_sys_fault_stop: assert property (sys_fault_q && main_q == power_seq_pkg::MAIN_ON
		|=> main_q != power_seq_pkg::MAIN_ON) else $error("system fault left main on");
	chk_pg_settle: assert property ($rose(power_good_out)
		|-> $past(pg_del_q) >= power_seq_pkg::PG_DELAY_TICKS) else $error("power good early");
	chk_pg_warn_time: assert property ($fell(main_rail_en) && $past(main_q) ==
		power_seq_pkg::MAIN_WARN |-> pg_low_cyc_q >= WARN_W'(WARN_CYC))
		else $error("main dropped too soon after power good");
	chk_pg_low_hold: assert property ($fell(power_good_out) |=> !power_good_out [*8])
		else $error("power good re-asserted too soon");
	chk_main_off_time: assert property (oe_off_cyc_q <= WARN_W'(WARN_CYC + 1))
		else $error("main rail not disabled in time");
	chk_oe_drops_pg: assert property ($rose(s.output_enable_n) |=> !power_good_out)
		else $error("power good stayed after enable removed");
	chk_main_after_seq: assert property ($rose(main_rail_en)
		|-> $past(main_q) == power_seq_pkg::MAIN_DELAY && standby_rail_en)
		else $error("main started outside sequence");
	chk_fault_clear: assert property (oe_rise && !prot_event |=> !prot_fault_q)
		else $error("latched fault not cleared");
	chk_alert_amber: assert property (!alert_out_n == (led_mode_q == power_seq_pkg::LED_AMBER
		|| led_mode_q == power_seq_pkg::LED_AMBER_SLOW)) else $error("alert and amber differ");

endmodule

// ==== include/power_seq_pkg.sv ====
// constants, pin bundle and state types shared by the power status sequencer
// assumes a single 25 MHz core clock; every time below except T_PG_WARN_MS (counted in core cycles) is counted in ms ticks
package power_seq_pkg;

	// core clock and derived millisecond tick
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned MS_PER_S   = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

	// all ms-tick counters share one width, wide enough for the 1 s back-off
	localparam int unsigned MS_CNT_W = 10;
	typedef logic [MS_CNT_W-1:0] ms_cnt_t;

	// documented times, in their own unit
	localparam int unsigned T_PG_DEL_MIN_MS  = 5;
	localparam int unsigned T_PG_DEL_MAX_MS  = 400;
	localparam int unsigned T_PG_WARN_MS     = 1;
	localparam int unsigned T_PG_HOLDUP_MS   = 4;
	localparam int unsigned T_PG_LOW_MS      = 100;
	localparam int unsigned T_RAIL_OFF_S     = 1;
	localparam int unsigned T_SEQ_MIN_MS     = 50;
	localparam int unsigned T_SEQ_MAX_MS     = 1000;
	localparam int unsigned BLINK_SLOW_HZ    = 1;
	localparam int unsigned BLINK_FAST_HZ    = 2;

	// tick counts; hold-up and low-hold minimums get one extra tick because the first tick may come early; power good delay is doubled, sequence delay gets 10 extra
	localparam ms_cnt_t PG_DELAY_TICKS  = ms_cnt_t'(T_PG_DEL_MIN_MS * 2);
	localparam ms_cnt_t HOLDUP_TICKS    = ms_cnt_t'(T_PG_HOLDUP_MS + 1);
	localparam ms_cnt_t PG_LOW_TICKS    = ms_cnt_t'(T_PG_LOW_MS + 1);
	localparam ms_cnt_t RAIL_OFF_TICKS  = ms_cnt_t'(T_RAIL_OFF_S * MS_PER_S);
	localparam ms_cnt_t SEQ_DELAY_TICKS = ms_cnt_t'(T_SEQ_MIN_MS + 10);
	localparam ms_cnt_t SLOW_HALF_TICKS = ms_cnt_t'(MS_PER_S / (2 * BLINK_SLOW_HZ));
	localparam ms_cnt_t FAST_HALF_TICKS = ms_cnt_t'(MS_PER_S / (2 * BLINK_FAST_HZ));

	// every asynchronous status and control pin, synchronised as one vector
	typedef struct packed {
		logic dc_input_ok;
		logic standby_rail_ok;
		logic main_rail_ok;
		logic output_enable_n;
		logic fan_boost_request_n;
		logic system_fault_shutdown;
		logic paralleled_standby_ok;
		logic over_temp_shutdown;
		logic over_voltage_shutdown;
		logic over_current_shutdown;
		logic fan_error_major;
		logic fan_error_minor;
		logic over_temp_warning;
		logic bootload_active;
	} pins_s;

	// reset value of the synchroniser: active-low pins idle high
	localparam pins_s PINS_RST = '{output_enable_n: 1'b1, fan_boost_request_n: 1'b1,
		default: 1'b0};

	typedef enum logic [2:0] {
		LED_OFF,
		LED_GREEN_SLOW,
		LED_AMBER,
		LED_AMBER_SLOW,
		LED_GREEN_FAST,
		LED_GREEN
	} led_e;

	typedef enum logic [2:0] {
		MAIN_IDLE,
		MAIN_DELAY,
		MAIN_ON,
		MAIN_WARN,
		MAIN_BACKOFF
	} main_e;

endpackage

// ==== verif/power_status_sequencer_tb.sv ====
// self-checking bench of the power status sequencer
// assumes rail_model as the converters; 1 ms is shortened to P cycles
`timescale 1ns/1ps
module power_status_sequencer_tb;
	localparam int P = 10;
	localparam int SB = 0, MN = 1, PG = 2, FAN = 3, GRN = 4, AMB = 5, ALN = 6, MOK = 7;
	logic                 core_clk = 1'b0;
	logic                 reset_n = 1'b0;
	logic                 kill = 1'b0;
	logic                 sb_ok;
	logic                 mn_ok;
	logic                 sb_en, mn_en, pg, fan, grn, amb, alert_n;
	logic [7:0]           outs;
	power_seq_pkg::pins_s p = power_seq_pkg::PINS_RST;
	power_seq_pkg::pins_s pins;
	int                   mismatches = 0;
	int                   n_checks = 0;
	int                   cyc = 0;

	// clock and rail feedback merged into the pin vector
	always #20 core_clk = ~core_clk;
	assign outs = {mn_ok, alert_n, amb, grn, fan, pg, mn_en, sb_en};
	always_comb begin
		pins = p;
		pins.standby_rail_ok = sb_ok;
		pins.main_rail_ok = mn_ok;
	end

	power_status_sequencer #(.CYC_PER_MS(P)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
		.pins_in(pins), .standby_rail_en(sb_en), .main_rail_en(mn_en),
		.power_good_out(pg), .fan_max_out(fan), .led_green(grn), .led_amber(amb),
		.alert_out_n(alert_n));
	rail_model #(.RISE(2 * P)) u_rails (.core_clk(core_clk), .standby_rail_en(sb_en),
		.main_rail_en(mn_en), .main_kill(kill), .standby_rail_ok(sb_ok), .main_rail_ok(mn_ok));

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard: the whole run needs about 50k cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// inputs always change 1 ns after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// cycles until output idx reads val, capped at lim
	task automatic wait_out(input int idx, input logic val, input int lim, output int n);
		n = 0;
		while (outs[idx] !== val && n < lim) begin
			step(1);
			n++;
		end
	endtask

	// one full half period of a blinking led, after aligning to a toggle
	task automatic half(input int idx, output int n);
		wait_out(idx, ~outs[idx], 600 * P, n);
		wait_out(idx, ~outs[idx], 600 * P, n);
	endtask

	task automatic t_reset();
		int n;
		step(16);
		check(outs, 8'h40); // in reset only alert_n stands high
		reset_n = 1'b1;
		step(5);
		check(outs, 8'h40);
		p.dc_input_ok = 1'b1;
		wait_out(SB, 1'b1, 10, n);
		check(n < 10, 1'b1);
		step(3 * P);
	endtask

	task automatic t_power_up();
		int n;
		p.output_enable_n = 1'b0;
		wait_out(MOK, 1'b1, 500 * P, n);
		check(n >= 5 * P && n <= 400 * P, 1'b1);
		check(n >= 50 * P && n <= 1000 * P, 1'b1);
		wait_out(PG, 1'b1, 500 * P, n);
		check(n >= 5 * P && n <= 400 * P, 1'b1);
		step(5);
		check({alert_n, amb, grn}, 3'b101);
		p.fan_boost_request_n = 1'b0;
		step(5);
		check(fan, 1'b1);
		p.fan_boost_request_n = 1'b1;
	endtask

	task automatic t_off_on();
		int n, m, k;
		p.output_enable_n = 1'b1;
		wait_out(PG, 1'b0, 10 * P, n);
		check(n <= 4 * P, 1'b1);
		wait_out(MN, 1'b0, 10 * P, m);
		check(n + m <= P + 3, 1'b1);
		check(m >= P, 1'b1);
		p.fan_boost_request_n = 1'b0;
		step(5);
		check(fan, 1'b0);
		p.fan_boost_request_n = 1'b1;
		// re-enable at once: rail delay alone is shorter than the low hold
		p.output_enable_n = 1'b0;
		wait_out(PG, 1'b1, 300 * P, k);
		check(m + 5 + k >= 100 * P, 1'b1);
	endtask

	task automatic t_amber();
		int n;
		int sd[4] = '{6, 5, 4, 3};
		p.over_temp_warning = 1'b1;
		step(5);
		check({alert_n, grn}, 2'b00);
		half(AMB, n);
		check(n, 500 * P);
		// warning stays set so each of the three protection shutdowns and the major fan error must outrank it
		for (int i = 0; i < 4; i++) begin
			p[sd[i]] = 1'b1;
			step(5);
			check({alert_n, amb, grn}, 3'b010);
			if (i == 0) begin
				wait_out(AMB, 1'b0, 600 * P, n);
				check(n, 600 * P);
			end
			p[sd[i]] = 1'b0;
			p.output_enable_n = 1'b1;
			step(5);
			p.output_enable_n = 1'b0;
		end
		p.over_temp_warning = 1'b0;
		wait_out(PG, 1'b1, 300 * P, n);
		check(n < 300 * P, 1'b1);
	endtask

	task automatic t_blink();
		int n;
		p.output_enable_n = 1'b1;
		p.bootload_active = 1'b1;
		step(5);
		check(amb, 1'b0);
		half(GRN, n);
		check(n, 500 * P);
		p.output_enable_n = 1'b0;
		wait_out(PG, 1'b1, 300 * P, n);
		half(GRN, n);
		check(n, 250 * P);
		p.bootload_active = 1'b0;
	endtask

	task automatic t_fault();
		int n;
		p.system_fault_shutdown = 1'b1;
		// main keeps its 1 ms warning before the rail is dropped
		step(2 * P);
		check(outs[2:0], 3'b000);
		p.system_fault_shutdown = 1'b0;
		step(5);
		check(sb_en, 1'b0);
		p.output_enable_n = 1'b1;
		wait_out(SB, 1'b1, 1100 * P, n);
		check(n < 1100 * P, 1'b1);
		p.output_enable_n = 1'b0;
		wait_out(PG, 1'b1, 300 * P, n);
		check(n < 300 * P, 1'b1);
	endtask

	task automatic t_dropout();
		int n;
		kill = 1'b1;
		wait_out(MN, 1'b0, 10, n);
		check(outs[PG:MN], 2'b00);
		kill = 1'b0;
		wait_out(MN, 1'b1, 1200 * P, n);
		check(n >= 1000 * P, 1'b1);
		wait_out(PG, 1'b1, 300 * P, n);
		check(n < 300 * P, 1'b1);
	endtask

	task automatic t_dc_loss();
		int n;
		p.dc_input_ok = 1'b0;
		wait_out(PG, 1'b0, 10 * P, n);
		check(n >= 4 * P && n < 10 * P, 1'b1);
		// standby from a paralleled unit turns the dark led into a slow green blink
		p.paralleled_standby_ok = 1'b1;
		half(GRN, n);
		check(n, 500 * P);
		p.paralleled_standby_ok = 1'b0;
		step(5);
		check({alert_n, amb, grn}, 3'b100);
	endtask

	// main sequence
	initial begin
		t_reset();
		t_power_up();
		t_off_on();
		t_amber();
		t_blink();
		t_fault();
		t_dropout();
		t_dc_loss();
		final_report();
	end
endmodule

// ==== verif/rail_model.sv ====
// converter model standing for the rails that the sequencer enables
// assumes the sequencer's core_clk; main_kill forces a main rail dropout
`timescale 1ns/1ps
module rail_model #(
	parameter int unsigned RISE = 20
) (
	input  wire logic core_clk,
	input  wire logic standby_rail_en,
	input  wire logic main_rail_en,
	input  wire logic main_kill,
	output logic      standby_rail_ok,
	output logic      main_rail_ok
);
	int unsigned sb_n = 0;
	int unsigned mn_n = 0;

	// soft start: a rail reports good only RISE cycles after its enable
	// hold-up is not modelled, so a dropped enable loses regulation at once
	always_ff @(posedge core_clk) begin
		sb_n <= standby_rail_en ? ((sb_n < RISE) ? sb_n + 1 : sb_n) : 0;
		mn_n <= (main_rail_en && !main_kill) ? ((mn_n < RISE) ? mn_n + 1 : mn_n) : 0;
	end

	// a kill drops regulation in the same cycle, harsher than a real rail
	assign standby_rail_ok = (sb_n >= RISE);
	assign main_rail_ok    = (mn_n >= RISE) && !main_kill;
endmodule
